// [common/pcg_pkg.sv]
// Purpose: Constants for the peripheral clock gating block
// Assumes: AHB-Lite slave, 32-bit data, word registers
// Notes:   Offsets and bit positions shared by design and bench
package pcg_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] OFS_POWER_REDUCTION = 8'h00;
	localparam logic [7:0] OFS_MCU_CONTROL     = 8'h04;
	localparam logic [7:0] OFS_LOWPOWER_CTRL   = 8'h08;
	localparam logic [7:0] OFS_STATUS          = 8'h0C;
	localparam logic [7:0] RST_POWER_REDUCTION = 8'h00;
	localparam logic [7:0] PRR_WRITABLE        = 8'hEF;
	localparam logic [2:0] BOD_DISABLED        = 3'h7;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int BIT_CONVERTER     = 0;
	localparam int BIT_USART_FIRST   = 1;
	localparam int BIT_SERIAL_PERIPH = 2;
	localparam int BIT_TIMER1        = 3;
	localparam int BIT_RESERVED      = 4;
	localparam int BIT_TIMER0        = 5;
	localparam int BIT_TIMER2        = 6;
	localparam int BIT_TWO_WIRE      = 7;
	localparam int BIT_SCAN_DISABLE  = 0;
	// Low-power control: [0] comparator enable, [1] comparator uses reference,
	// [2] converter enable
	localparam int BIT_CMP_ENABLE    = 0;
	localparam int BIT_CMP_USE_REF   = 1;
	localparam int BIT_ADC_ENABLE    = 2;
	localparam int NUM_PERIPH        = 8;

	// ----------------------------------------
	// Sleep modes
	// ----------------------------------------
	localparam logic [2:0] SLP_IDLE      = 3'h0;
	localparam logic [2:0] SLP_ADC_NR    = 3'h1;
	localparam logic [2:0] SLP_PWR_DOWN  = 3'h2;
	localparam logic [2:0] SLP_PWR_SAVE  = 3'h3;
	localparam logic [2:0] SLP_STANDBY   = 3'h6;
	localparam logic [2:0] SLP_EXT_STBY  = 3'h7;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage : pcg_pkg

// [hdl/pcg_top.sv]
// Purpose: Per-peripheral clock gating and low-power interplay with sleep
// Assumes: Single 200 MHz clock; one-cycle AHB-Lite answers, always OKAY
// Notes:   Gates are latch-free enables registered on the clock edge
module pcg_top
	import pcg_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        sleeping,
	input  wire logic [2:0]  sleep_mode,
	input  wire logic        timer2_async_select,
	input  wire logic [2:0]  brownout_level_fuses,
	input  wire logic        watchdog_enable,
	input  wire logic        debug_enable_fuse,
	input  wire logic        scan_port_enable_fuse,
	input  wire logic        wake_pin_needed,
	output logic      [7:0]  periph_clk_en,
	output logic      [7:0]  periph_access_en,
	output logic             cmp_mux_allowed,
	output logic             cmp_active,
	output logic             adc_extended_next,
	output logic             vref_enable,
	output logic             brownout_active,
	output logic             watchdog_active,
	output logic             input_buf_enable,
	output logic             main_clk_keep,
	output logic             debug_active
);

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	logic [7:0] power_reduction;
	logic [0:0] mcu_control;
	logic [2:0] lowpower_ctrl;
	logic       wr_pend;
	logic [7:0] wr_addr;
	logic       adc_conv_done;

	function automatic logic [31:0] read_mux(input logic [7:0] a);
		case (a)
			OFS_POWER_REDUCTION: read_mux = {24'h000000, power_reduction & PRR_WRITABLE};
			OFS_MCU_CONTROL:     read_mux = {31'h00000000, mcu_control};
			OFS_LOWPOWER_CTRL:   read_mux = {29'h00000000, lowpower_ctrl};
			OFS_STATUS:          read_mux = {23'h000000, adc_extended_next, periph_clk_en};
			default:             read_mux = 32'h00000000;
		endcase
	endfunction

	wire req = hsel && hready && (htrans == HTRANS_NONSEQ);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end
		else
		begin
			wr_pend <= req && hwrite;
			wr_addr <= haddr;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h00000000;
		else if (req && !hwrite)
			hrdata <= read_mux(haddr);
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
		else
		begin
			// Zero-wait slave; unmapped addresses read zero, writes dropped
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			power_reduction <= RST_POWER_REDUCTION;
		else if (wr_pend && wr_addr == OFS_POWER_REDUCTION)
			power_reduction <= hwdata[7:0] & PRR_WRITABLE;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			mcu_control <= 1'b0;
		else if (wr_pend && wr_addr == OFS_MCU_CONTROL)
			mcu_control <= hwdata[BIT_SCAN_DISABLE];
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			lowpower_ctrl <= 3'h0;
		else if (wr_pend && wr_addr == OFS_LOWPOWER_CTRL)
			lowpower_ctrl <= hwdata[2:0];
	end

	// ----------------------------------------
	// Sleep decode
	// ----------------------------------------
	// Io clock runs only in active and idle; adc clock also in noise reduction
	wire io_clk_run  = !sleeping || sleep_mode == SLP_IDLE;
	wire adc_clk_run = io_clk_run || sleep_mode == SLP_ADC_NR;

	// ----------------------------------------
	// Clock gates
	// ----------------------------------------
	logic [7:0] next_clk_en;

	always_comb
	begin
		next_clk_en = ~power_reduction;
		next_clk_en[BIT_RESERVED] = 1'b0;
		// Asynchronous timer2 runs off its own oscillator: its register bit is ignored, but every sleep mode other than idle still stops it
		if (timer2_async_select)
			next_clk_en[BIT_TIMER2] = 1'b1;
		// Deep sleeps stop every gated clock; converter survives noise reduction
		if (!io_clk_run)
			next_clk_en = next_clk_en & {{(NUM_PERIPH - 1){1'h0}}, adc_clk_run};
	end

	// Registered enable feeds a clock-gate cell that samples it while low
	generate
		for (genvar i = 0; i < NUM_PERIPH; i++)
		begin : g_gate
			always_ff @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
					periph_clk_en[i] <= (i != BIT_RESERVED);
				else
					periph_clk_en[i] <= next_clk_en[i];
			end

			always_ff @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
					periph_access_en[i] <= 1'b1;
				else
					periph_access_en[i] <= !power_reduction[i];
			end
		end
	endgenerate

	// ----------------------------------------
	// Analog and system power
	// ----------------------------------------
	logic adc_en_d;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cmp_mux_allowed <= 1'b1;
			cmp_active      <= 1'b0;
			vref_enable     <= 1'b0;
			adc_en_d        <= 1'b0;
		end
		else
		begin
			cmp_mux_allowed <= !power_reduction[BIT_CONVERTER];
			cmp_active      <= lowpower_ctrl[BIT_CMP_ENABLE] &&
				(!sleeping || sleep_mode == SLP_IDLE || sleep_mode == SLP_ADC_NR);
			vref_enable     <= (brownout_level_fuses != BOD_DISABLED) ||
				(lowpower_ctrl[BIT_CMP_ENABLE] && lowpower_ctrl[BIT_CMP_USE_REF]) ||
				lowpower_ctrl[BIT_ADC_ENABLE];
			adc_en_d        <= lowpower_ctrl[BIT_ADC_ENABLE];
		end
	end

	// Conversion completion approximated as enable held with converter clock running
	assign adc_conv_done = adc_en_d && periph_clk_en[BIT_CONVERTER];

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			adc_extended_next <= 1'b1;
		else if (lowpower_ctrl[BIT_ADC_ENABLE] && !adc_en_d)
			adc_extended_next <= 1'b1;
		else if (adc_conv_done)
			adc_extended_next <= 1'b0;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			brownout_active  <= 1'b0;
			watchdog_active  <= 1'b0;
			input_buf_enable <= 1'b1;
			main_clk_keep    <= 1'b0;
			debug_active     <= 1'b0;
		end
		else
		begin
			brownout_active  <= brownout_level_fuses != BOD_DISABLED;
			watchdog_active  <= watchdog_enable;
			input_buf_enable <= adc_clk_run || wake_pin_needed;
			debug_active     <= debug_enable_fuse && scan_port_enable_fuse &&
				!mcu_control[BIT_SCAN_DISABLE];
			main_clk_keep    <= sleeping && debug_enable_fuse && scan_port_enable_fuse &&
				!mcu_control[BIT_SCAN_DISABLE];
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	gate_follows_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(!sleeping && !timer2_async_select) |=>
		periph_clk_en == (~$past(power_reduction) & PRR_WRITABLE))
		else $error("gate enable does not follow register");
	reserved_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!power_reduction[BIT_RESERVED] && !periph_clk_en[BIT_RESERVED])
		else $error("reserved bit set");
	access_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
		power_reduction[BIT_TIMER0] |=> !periph_access_en[BIT_TIMER0])
		else $error("access allowed while gated");
	timer2_async_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(timer2_async_select && !sleeping) |=> periph_clk_en[BIT_TIMER2])
		else $error("async timer2 gated");
	deep_sleep_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(sleeping && sleep_mode == SLP_PWR_DOWN) |=> periph_clk_en[BIT_TIMER1] == 1'b0)
		else $error("clock runs in deep sleep");
	mux_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
		power_reduction[BIT_CONVERTER] |=> !cmp_mux_allowed)
		else $error("comparator mux usable while converter gated");
	cmp_auto_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(sleeping && sleep_mode == SLP_STANDBY) |=> !cmp_active)
		else $error("comparator active in deep sleep");
	ext_conv_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(lowpower_ctrl[BIT_ADC_ENABLE]) |=> adc_extended_next)
		else $error("extended conversion not armed");
	debug_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
		mcu_control[BIT_SCAN_DISABLE] |=> !debug_active ##0 !main_clk_keep)
		else $error("debug active after disable");
	buf_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(sleeping && sleep_mode == SLP_PWR_SAVE && !wake_pin_needed) |=> !input_buf_enable)
		else $error("input buffers on in deep sleep");
	vref_on_a: assert property (@(posedge hclk) disable iff (!hresetn)
		lowpower_ctrl[BIT_ADC_ENABLE] |=> vref_enable)
		else $error("reference off while converter on");
	bod_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(brownout_level_fuses != BOD_DISABLED) |=> brownout_active)
		else $error("brown-out inactive");
	wdt_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
		watchdog_enable |=> watchdog_active)
		else $error("watchdog stopped");

	// ----------------------------------------
	// Checks on individual gates
	// ----------------------------------------
	// One check per bit so a swapped bit map shows up by name
	two_wire_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
		power_reduction[BIT_TWO_WIRE] |=> !periph_clk_en[BIT_TWO_WIRE])
		else $error("two-wire clock runs while gated");
	timer2_sync_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(power_reduction[BIT_TIMER2] && !timer2_async_select) |=>
		!periph_clk_en[BIT_TIMER2])
		else $error("synchronous timer2 clock runs while gated");
	timer0_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
		power_reduction[BIT_TIMER0] |=> !periph_clk_en[BIT_TIMER0])
		else $error("timer0 clock runs while gated");
	timer1_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
		power_reduction[BIT_TIMER1] |=> !periph_clk_en[BIT_TIMER1])
		else $error("timer1 clock runs while gated");
	serial_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
		power_reduction[BIT_SERIAL_PERIPH] |=> !periph_clk_en[BIT_SERIAL_PERIPH])
		else $error("serial peripheral clock runs while gated");
	usart_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
		power_reduction[BIT_USART_FIRST] |=> !periph_clk_en[BIT_USART_FIRST])
		else $error("usart clock runs while gated");
	conv_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
		power_reduction[BIT_CONVERTER] |=> !periph_clk_en[BIT_CONVERTER])
		else $error("converter clock runs while gated");
	timer1_restart_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(!sleeping && $fell(power_reduction[BIT_TIMER1])) |=> periph_clk_en[BIT_TIMER1])
		else $error("timer1 clock not restarted");
	access_open_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!power_reduction[BIT_SERIAL_PERIPH] |=> periph_access_en[BIT_SERIAL_PERIPH])
		else $error("access blocked while clock runs");
	// Enables may move only when the register, the sleep state or timer2's source moved
	gate_stable_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(!sleeping && !$past(sleeping) && $stable(power_reduction) &&
		$stable(timer2_async_select)) |=> $stable(periph_clk_en))
		else $error("gate enable moved without cause");
	idle_run_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(sleeping && sleep_mode == SLP_IDLE && !power_reduction[BIT_USART_FIRST]) |=>
		periph_clk_en[BIT_USART_FIRST])
		else $error("usart clock stopped in idle");
	noise_red_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(sleeping && sleep_mode == SLP_ADC_NR && !power_reduction[BIT_CONVERTER]) |=>
		(periph_clk_en[BIT_CONVERTER] && !periph_clk_en[BIT_USART_FIRST]))
		else $error("wrong clocks in noise reduction");
	deep_all_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(sleeping && sleep_mode != SLP_IDLE && sleep_mode != SLP_ADC_NR) |=>
		periph_clk_en == '0)
		else $error("gated clock runs in deep sleep");

	// ----------------------------------------
	// Checks on bus and power side
	// ----------------------------------------
	rd_reserved_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(req && !hwrite && haddr == OFS_POWER_REDUCTION) |=> !hrdata[BIT_RESERVED])
		else $error("reserved bit read as one");
	write_lands_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_pend && wr_addr == OFS_POWER_REDUCTION) |=>
		power_reduction == ($past(hwdata[7:0]) & PRR_WRITABLE))
		else $error("gating register write lost");
	ext_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(adc_extended_next && !periph_clk_en[BIT_CONVERTER]) |=> adc_extended_next)
		else $error("extended conversion lost while gated");
	cmp_run_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(lowpower_ctrl[BIT_CMP_ENABLE] && (!sleeping || sleep_mode == SLP_ADC_NR)) |=>
		cmp_active)
		else $error("comparator off while allowed");
	cmp_deep_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(sleeping && sleep_mode != SLP_IDLE && sleep_mode != SLP_ADC_NR) |=>
		!cmp_active)
		else $error("comparator on in deep sleep");
	vref_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(brownout_level_fuses == BOD_DISABLED && !lowpower_ctrl[BIT_ADC_ENABLE] &&
		!lowpower_ctrl[BIT_CMP_USE_REF]) |=> !vref_enable)
		else $error("reference on with no user");
	buf_on_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(!sleeping || wake_pin_needed) |=> input_buf_enable)
		else $error("input buffers off while needed");
	clk_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(sleeping && debug_enable_fuse && scan_port_enable_fuse &&
		!mcu_control[BIT_SCAN_DISABLE]) |=> main_clk_keep)
		else $error("main clock dropped while debugging");
	fuse_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(!debug_enable_fuse || !scan_port_enable_fuse) |=>
		(!debug_active && !main_clk_keep))
		else $error("debug active with fuse off");
	debug_on_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(debug_enable_fuse && scan_port_enable_fuse && !mcu_control[BIT_SCAN_DISABLE]) |=>
		debug_active)
		else $error("debug inactive while enabled");

endmodule // pcg_top

// [verif/pcg_tb_top.sv]
// Purpose: Self-checking bench for the peripheral clock gating block
// Assumes: One-cycle AHB-Lite answers; side outputs settle within two edges
// Notes:   Reserved bit 4 is masked out of enable comparisons
module pcg_tb_top
	import pcg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------
	logic        hclk      = 1'b0;
	logic        hresetn   = 1'b0;
	logic        hsel      = 1'b0;
	logic [7:0]  haddr     = 8'h00;
	logic [1:0]  htrans    = 2'h0;
	logic        hwrite    = 1'b0;
	logic [2:0]  hsize     = 3'h2;
	logic [31:0] hwdata    = 32'h0;
	logic        sleeping  = 1'b0;
	logic [2:0]  sleep_mode = 3'h0;
	logic        t2_async  = 1'b0;
	logic [2:0]  bod_fuses = 3'h7;
	logic        wdt_en    = 1'b0;
	logic        dbg_fuse  = 1'b0;
	logic        scan_fuse = 1'b0;
	logic        wake_pin  = 1'b0;
	logic [31:0] hrdata;
	logic        hready;
	logic        hresp;
	logic [7:0]  clk_en;
	logic [7:0]  acc_en;
	logic        mux_ok, cmp_on, ext_next, vref, bod_on, wdt_on, ibuf, keep, dbg_on;
	logic [31:0] rd;
	logic [2:0]  modes [0:5];
	int          n_mismatch  = 0;
	int          checks_done = 0;
	int          cycles      = 0;

	pcg_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
		.sleeping(sleeping), .sleep_mode(sleep_mode), .timer2_async_select(t2_async),
		.brownout_level_fuses(bod_fuses), .watchdog_enable(wdt_en),
		.debug_enable_fuse(dbg_fuse), .scan_port_enable_fuse(scan_fuse),
		.wake_pin_needed(wake_pin), .periph_clk_en(clk_en), .periph_access_en(acc_en),
		.cmp_mux_allowed(mux_ok), .cmp_active(cmp_on), .adc_extended_next(ext_next),
		.vref_enable(vref), .brownout_active(bod_on), .watchdog_active(wdt_on),
		.input_buf_enable(ibuf), .main_clk_keep(keep), .debug_active(dbg_on));

	always #2.5 hclk = ~hclk;

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task finish_test;
		$display("Mismatches %0d, checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task wait_ready;
		do @(posedge hclk); while (hready !== 1'b1);
	endtask

	// One single transfer; read data lands in rd
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		wait_ready;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready;
		rd = hrdata;
	endtask

	task settle;
		repeat (2) @(posedge hclk);
	endtask

	// ----------------------------------------
	// Hang guard, generous for about 150 cycles of tests
	// ----------------------------------------
	always @(posedge hclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_mismatch++;
			finish_test;
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		modes = '{SLP_IDLE, SLP_ADC_NR, SLP_PWR_DOWN, SLP_PWR_SAVE, SLP_STANDBY, SLP_EXT_STBY};
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		settle;
		chk("clk_en reset", 32'(clk_en & 8'hEF), 32'h0000_00EF);
		bus(1'b0, OFS_POWER_REDUCTION, 32'h0);
		chk("prr reset", rd, 32'h0);
		chk("hresp", 32'(hresp), 32'h0);
		for (int i = 0; i < NUM_PERIPH; i++)
		begin
			if (i == BIT_RESERVED)
				continue;
			bus(1'b1, OFS_POWER_REDUCTION, 32'h1 << i);
			settle;
			chk("clk_en", 32'(clk_en & 8'hEF), 32'(~(8'h01 << i) & 8'hEF));
			chk("access_en", 32'(acc_en & 8'hEF), 32'(~(8'h01 << i) & 8'hEF));
			bus(1'b0, OFS_POWER_REDUCTION, 32'h0);
			chk("prr", rd, 32'h1 << i);
		end
		bus(1'b1, OFS_POWER_REDUCTION, 32'hFFFF_FFFF);
		bus(1'b0, OFS_POWER_REDUCTION, 32'h0);
		chk("prr reserved", rd, 32'h0000_00EF);
		bus(1'b1, OFS_POWER_REDUCTION, 32'h0);
		settle;
		chk("clk_en restart", 32'(clk_en & 8'hEF), 32'h0000_00EF);
		bus(1'b1, OFS_POWER_REDUCTION, 32'h40);
		t2_async <= 1'b1;
		settle;
		chk("timer2 async", 32'(clk_en[6]), 32'h1);
		t2_async <= 1'b0;
		settle;
		chk("timer2 sync", 32'(clk_en[6]), 32'h0);
		// Converter gated first, then enabled: no conversion can run yet
		bus(1'b1, OFS_LOWPOWER_CTRL, 32'h0);
		bus(1'b1, OFS_POWER_REDUCTION, 32'h01);
		bus(1'b1, OFS_LOWPOWER_CTRL, 32'h4);
		settle;
		chk("mux blocked", 32'(mux_ok), 32'h0);
		chk("extended pending", 32'(ext_next), 32'h1);
		bus(1'b0, OFS_STATUS, 32'h0);
		chk("status", rd, 32'h0000_01EE);
		bus(1'b1, OFS_POWER_REDUCTION, 32'h0);
		settle;
		settle;
		chk("mux free", 32'(mux_ok), 32'h1);
		chk("extended done", 32'(ext_next), 32'h0);
		bus(1'b1, OFS_LOWPOWER_CTRL, 32'h3);
		settle;
		chk("vref cmp", 32'(vref), 32'h1);
		bus(1'b1, OFS_LOWPOWER_CTRL, 32'h1);
		settle;
		chk("vref none", 32'(vref), 32'h0);
		bod_fuses <= 3'h6;
		settle;
		chk("vref bod", 32'(vref), 32'h1);
		// Sleep interplay: comparator on, SPI gated
		bus(1'b1, OFS_POWER_REDUCTION, 32'h04);
		sleeping <= 1'b1;
		wdt_en <= 1'b1;
		dbg_fuse <= 1'b1;
		scan_fuse <= 1'b1;
		for (int i = 0; i < 6; i++)
		begin
			sleep_mode <= modes[i];
			settle;
			chk("cmp", 32'(cmp_on), 32'(i < 2));
			chk("ibuf", 32'(ibuf), 32'(i < 2));
			chk("adc clk", 32'(clk_en[0]), 32'(i < 2));
			chk("usart clk", 32'(clk_en[1]), 32'(i == 0));
			chk("spi clk", 32'(clk_en[2]), 32'h0);
			chk("bod", 32'(bod_on), 32'h1);
			chk("wdt", 32'(wdt_on), 32'h1);
			chk("keep", 32'(keep), 32'h1);
		end
		wake_pin <= 1'b1;
		settle;
		chk("ibuf wake", 32'(ibuf), 32'h1);
		chk("dbg on", 32'(dbg_on), 32'h1);
		dbg_fuse <= 1'b0;
		settle;
		chk("dbg fuse", 32'(dbg_on), 32'h0);
		dbg_fuse <= 1'b1;
		scan_fuse <= 1'b0;
		settle;
		chk("dbg scan", 32'(dbg_on), 32'h0);
		scan_fuse <= 1'b1;
		bus(1'b1, OFS_MCU_CONTROL, 32'h1);
		settle;
		chk("dbg bit", 32'(dbg_on), 32'h0);
		chk("keep off", 32'(keep), 32'h0);
		bus(1'b0, OFS_MCU_CONTROL, 32'h0);
		chk("mcu ctl", rd, 32'h1);
		sleeping <= 1'b0;
		bus(1'b0, 8'h10, 32'h0);
		chk("unmapped", rd, 32'h0);
		finish_test;
	end
endmodule // pcg_tb_top
